// *** shared/pll_synth_pkg.sv ***
// constants, types and helpers shared by the synthesizer core
//Contract
//- serial data is shifted in on each falling shift clock edge
//- the 21st falling edge loads the whole control word in one step
//- further shift clock pulses are ignored once 21 are counted
//- load clear resets the shift clock pulse counter
//- while load clear is high, shift clock and data are not accepted
//- bits 1-7 swallow, 8-17 main, 18-19 compare select, 20 A, 21 B
//- vco division ratio is two times swallow plus 256 times main
//- total ratio programmable in binary from 32768 to 262142
//- swallow counter switches prescaler between 256 and 258 moduli
//- compare select 00 gives 50k, 11 gives 6.25k, mixed 25k/12.5k
//- port outputs follow their control bits, updated at word load
//- polarity high: phase output low on lag, high on lead
//- polarity low: phase output level is inverted
//- lock low when every error pulse per period is under 625ns
//- test high: port A shows compare clock, port B divider output
//- an output clock is the reference divided by eight
//- the reference chain runs from a 12.8MHz oscillator
package pll_synth_pkg;

    // ******************************************************
    // control word
    // ******************************************************
    localparam int         WORD_BITS      = 21;
    localparam logic [4:0] LAST_PULSE     = 5'h14;
    localparam logic [4:0] LOAD_COUNT     = 5'h15;
    localparam int         SWALLOW_LSB    = 0;
    localparam int         SWALLOW_W      = 7;
    localparam int         MAIN_LSB       = 7;
    localparam int         MAIN_W         = 10;
    localparam int         CMP_SEL_LSB    = 17;
    localparam int         PORT_A_BIT     = 19;
    localparam int         PORT_B_BIT     = 20;

    // ******************************************************
    // timing
    // ******************************************************
    localparam int         REF_OSC_HZ     = 12800000;
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         LOCK_WINDOW_NS = 625;
    localparam int         LOCK_LIMIT_CYC =
        (LOCK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] DIV8_LAST      = 2'h3;
    localparam logic [10:0] CMP_DIV_BASE  = 11'h100;

    // ******************************************************
    // register map
    // ******************************************************
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam logic [11:0] REG_WORD      = 12'h008;
    localparam int          CTRL_RUN_BIT  = 0;
    localparam int          CTRL_CLR_BIT  = 1;
    localparam logic        CTRL_RUN_RST  = 1'h1;
    localparam int          STAT_LOCK_BIT = 0;
    localparam int          STAT_VLD_BIT  = 1;
    localparam int          STAT_CNT_LSB  = 2;

    typedef enum logic [1:0] {
        DIV_SWALLOW = 2'b01,
        DIV_MAIN    = 2'b10
    } div_state_t;

    // last count of the reference divider for a compare select code
    function automatic logic [10:0] cmp_div_last(input logic [1:0] sel);
        cmp_div_last = 11'((CMP_DIV_BASE << sel) - 11'h001);
    endfunction

endpackage

// *** src/phase_cmp.sv ***
// three-state phase comparator with lock detector
`timescale 1ns/1ns
module phase_cmp (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic ref_pulse,
    input  wire logic div_pulse,
    input  wire logic polarity_sel,
    output logic      pd_q,
    output logic      pd_oe_n_q,
    output logic      lock_n_q
);
    logic       up_q, up_d, dn_q, dn_d, pd_d, oe_n_d;
    logic       wide_q, wide_d, lock_n_d, hit;
    logic [6:0] wcnt_q, wcnt_d;

    always_comb begin
        up_d = up_q | ref_pulse;
        dn_d = dn_q | div_pulse;
        if (up_d && dn_d) begin
            up_d = 1'b0;
            dn_d = 1'b0;
        end
        // dn set means the divided vco leads
        pd_d   = dn_q ^ ~polarity_sel;
        oe_n_d = ~(up_q | dn_q);
        hit    = wcnt_q == 7'(pll_synth_pkg::LOCK_LIMIT_CYC);
        wcnt_d = (up_q | dn_q) ? (hit ? wcnt_q : 7'(wcnt_q + 7'h01))
                               : 7'h00;
        wide_d   = wide_q | hit;
        lock_n_d = lock_n_q;
        if (ref_pulse) begin
            // a pulse still running at the period edge counts toward next
            lock_n_d = wide_q | hit;
            wide_d   = hit;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {up_q, dn_q, wide_q} <= 3'h0;
            pd_q      <= 1'b0;
            pd_oe_n_q <= 1'b1;
            lock_n_q  <= 1'b1;
            wcnt_q    <= 7'h00;
        end else begin
            {up_q, dn_q, wide_q} <= {up_d, dn_d, wide_d};
            pd_q      <= pd_d;
            pd_oe_n_q <= oe_n_d;
            lock_n_q  <= lock_n_d;
            wcnt_q    <= wcnt_d;
        end
    end

    AST_LAG: assert property (@(posedge core_clk) disable iff (!rstn)
        up_q && polarity_sel |=> !pd_oe_n_q && !pd_q)
        else $error("lag not driven low");
    AST_INV: assert property (@(posedge core_clk) disable iff (!rstn)
        dn_q && !polarity_sel |=> !pd_oe_n_q && !pd_q)
        else $error("inverted lead not driven low");
    AST_HIZ: assert property (@(posedge core_clk) disable iff (!rstn)
        !up_q && !dn_q |=> pd_oe_n_q)
        else $error("phase output driven without error");
    AST_LOCK: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(lock_n_q) |-> $past(ref_pulse))
        else $error("lock changed off a period edge");
    COV_LOCK: cover property (@(posedge core_clk) disable iff (!rstn)
        $fell(lock_n_q));

endmodule // phase_cmp

// *** src/serial_load_rx.sv ***
// three-wire serial loader: pulse counter, shift register, word latch
`timescale 1ns/1ns
module serial_load_rx (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        shift_clock,
    input  wire logic        serial_data,
    input  wire logic        load_clear,
    input  wire logic        soft_clear,
    output logic [20:0]      word_q,
    output logic             load_q,
    output logic [4:0]       count_q
);
    logic        sck_s1_q, sck_s2_q, sck_s3_q;
    logic        sd_s1_q, sd_s2_q, lc_s1_q, lc_s2_q;
    logic [20:0] shreg_q, shreg_d, word_d;
    logic [4:0]  count_d;
    logic        load_d;

    // ******************************************************
    // pin synchronisers
    // ******************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
            {sd_s1_q, sd_s2_q, lc_s1_q, lc_s2_q} <= 4'h0;
        end else begin
            {sck_s1_q, sck_s2_q, sck_s3_q} <= {shift_clock, sck_s1_q,
                                               sck_s2_q};
            {sd_s1_q, sd_s2_q} <= {serial_data, sd_s1_q};
            {lc_s1_q, lc_s2_q} <= {load_clear, lc_s1_q};
        end
    end

    // ******************************************************
    // shift and load
    // ******************************************************
    always_comb begin
        shreg_d = shreg_q;
        count_d = count_q;
        word_d  = word_q;
        load_d  = 1'b0;
        if (lc_s2_q || soft_clear) begin
            count_d = 5'h00;
        end else if (sck_s3_q && !sck_s2_q &&
                     count_q != pll_synth_pkg::LOAD_COUNT) begin
            // lsb arrives first and ends up at bit 0
            shreg_d = {sd_s2_q, shreg_q[20:1]};
            count_d = 5'(count_q + 5'h01);
            if (count_q == pll_synth_pkg::LAST_PULSE) begin
                word_d = shreg_d;
                load_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shreg_q <= 21'h000000;
            word_q  <= 21'h000000;
            count_q <= 5'h00;
            load_q  <= 1'b0;
        end else begin
            shreg_q <= shreg_d;
            word_q  <= word_d;
            count_q <= count_d;
            load_q  <= load_d;
        end
    end

    AST_CNT_MAX: assert property (@(posedge core_clk) disable iff (!rstn)
        count_q <= pll_synth_pkg::LOAD_COUNT)
        else $error("pulse counter passed 21");
    AST_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn)
        lc_s2_q |=> count_q == 5'h00 && !load_q)
        else $error("load clear did not hold counter");
    AST_LOAD21: assert property (@(posedge core_clk) disable iff (!rstn)
        load_q |-> count_q == pll_synth_pkg::LOAD_COUNT &&
                   $past(count_q) == pll_synth_pkg::LAST_PULSE)
        else $error("word loaded at wrong pulse");
    COV_LOAD: cover property (@(posedge core_clk) disable iff (!rstn)
        load_q);

endmodule // serial_load_rx

// *** src/serial_pll_synth_core.sv ***
// synthesizer core: dividers, port logic, apb registers
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module serial_pll_synth_core (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        shift_clock,
    input  wire logic        serial_data,
    input  wire logic        load_clear,
    input  wire logic        polarity_sel,
    input  wire logic        test_mode,
    input  wire logic        ref_osc_in,
    input  wire logic        prescaler_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             modulus_hi,
    output logic             port_out_a,
    output logic             port_out_b,
    output logic             phase_error_out,
    output logic             phase_error_oe_n,
    output logic             lock_n,
    output logic             ref_div8_clock
);
    // ******************************************************
    // declarations
    // ******************************************************
    logic [3:0]  in_s1_q, in_s2_q;
    logic        ref_s3_q, pre_s3_q, ref_rise, pre_rise;
    logic        test_s, pol_s;
    logic [20:0] word;
    logic        load;
    logic [4:0]  count;
    logic [6:0]  swallow;
    logic [9:0]  main_n;
    logic [1:0]  cmp_sel;
    logic [10:0] ref_last;

    logic [10:0] refcnt_q, refcnt_d;
    logic [1:0]  d8cnt_q, d8cnt_d;
    logic        div8_q, div8_d, ref_pulse_q, ref_pulse_d;
    logic        fcmp_q, fcmp_d;

    pll_synth_pkg::div_state_t state_q, state_d;
    logic [9:0]  pcnt_q, pcnt_d;
    logic        div_pulse_q, div_pulse_d, fdiv_q, fdiv_d;
    logic        modhi_q, modhi_d;
    logic        pa_q, pa_d, pb_q, pb_d;

    logic        run_q, run_d, clr_q, clr_d, valid_q, valid_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;
    logic        setup, wr_en;

    // ******************************************************
    // pin synchronisers
    // ******************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            in_s1_q  <= 4'h0;
            in_s2_q  <= 4'h0;
            ref_s3_q <= 1'b0;
            pre_s3_q <= 1'b0;
        end else begin
            in_s1_q  <= {test_mode, polarity_sel, ref_osc_in, prescaler_in};
            in_s2_q  <= in_s1_q;
            ref_s3_q <= in_s2_q[1];
            pre_s3_q <= in_s2_q[0];
        end
    end

    assign pre_rise = in_s2_q[0] && !pre_s3_q;
    assign ref_rise = in_s2_q[1] && !ref_s3_q;
    assign pol_s    = in_s2_q[2];
    assign test_s   = in_s2_q[3];

    // ******************************************************
    // serial loader and active word fields
    // ******************************************************
    serial_load_rx u_rx (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .shift_clock (shift_clock),
        .serial_data (serial_data),
        .load_clear  (load_clear),
        .soft_clear  (clr_q),
        .word_q      (word),
        .load_q      (load),
        .count_q     (count)
    );

    // field layout of the word
    assign swallow = word[pll_synth_pkg::SWALLOW_LSB +:
                          pll_synth_pkg::SWALLOW_W];
    assign main_n  = word[pll_synth_pkg::MAIN_LSB +: pll_synth_pkg::MAIN_W];
    assign cmp_sel = word[pll_synth_pkg::CMP_SEL_LSB +: 2];
    assign ref_last = pll_synth_pkg::cmp_div_last(
                          cmp_sel);

    // ******************************************************
    // reference chain, clocked by the 12.8MHz oscillator edges
    // ******************************************************
    always_comb begin
        refcnt_d    = refcnt_q;
        d8cnt_d     = d8cnt_q;
        div8_d      = div8_q;
        fcmp_d      = fcmp_q;
        ref_pulse_d = 1'b0;
        if (ref_rise) begin
            d8cnt_d = 2'(d8cnt_q + 2'h1);
            if (d8cnt_q == pll_synth_pkg::DIV8_LAST) begin
                div8_d = ~div8_q;
            end
            // >= so a shorter divisor loaded mid-count wraps at once
            if (refcnt_q >= ref_last) begin
                refcnt_d    = 11'h000;
                ref_pulse_d = run_q;
                fcmp_d      = ~fcmp_q;
            end else begin
                refcnt_d = 11'(refcnt_q + 11'h001);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            refcnt_q    <= 11'h000;
            d8cnt_q     <= 2'h0;
            div8_q      <= 1'b0;
            fcmp_q      <= 1'b0;
            ref_pulse_q <= 1'b0;
        end else begin
            refcnt_q    <= refcnt_d;
            d8cnt_q     <= d8cnt_d;
            div8_q      <= div8_d;
            fcmp_q      <= fcmp_d;
            ref_pulse_q <= ref_pulse_d;
        end
    end

    // ******************************************************
    // programmable divider with swallow control
    // ******************************************************
    // a frame is main_n prescaler cycles; the first swallow of them run
    // at 258, the rest at 256, giving 256*main + 2*swallow
    // main below 128 leaves the documented range, it is not blocked
    always_comb begin
        state_d     = state_q;
        pcnt_d      = pcnt_q;
        fdiv_d      = fdiv_q;
        div_pulse_d = 1'b0;
        if (!run_q) begin
            state_d = pll_synth_pkg::DIV_MAIN;
            pcnt_d  = 10'h000;
        end else if (pre_rise) begin
            if (11'({1'b0, pcnt_q} + 11'h001) >= {1'b0, main_n}) begin
                pcnt_d      = 10'h000;
                div_pulse_d = 1'b1;
                fdiv_d      = ~fdiv_q;
                state_d     = (swallow != 7'h00) ?
                              pll_synth_pkg::DIV_SWALLOW :
                              pll_synth_pkg::DIV_MAIN;
            end else begin
                pcnt_d = 10'(pcnt_q + 10'h001);
                case (state_q)
                    pll_synth_pkg::DIV_SWALLOW: begin
                        // >= so a smaller swallow loaded mid-phase ends it
                        if (pcnt_d >= {3'h0, swallow}) begin
                            state_d = pll_synth_pkg::DIV_MAIN;
                        end
                    end
                    pll_synth_pkg::DIV_MAIN: begin
                        state_d = pll_synth_pkg::DIV_MAIN;
                    end
                    default: begin
                        state_d = pll_synth_pkg::DIV_MAIN;
                    end
                endcase
            end
        end
        modhi_d = state_d == pll_synth_pkg::DIV_SWALLOW;
        // port pins open-collector: a high level means released
        pa_d = test_s ? fcmp_q : word[pll_synth_pkg::PORT_A_BIT];
        pb_d = test_s ? fdiv_q : word[pll_synth_pkg::PORT_B_BIT];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q     <= pll_synth_pkg::DIV_MAIN;
            pcnt_q      <= 10'h000;
            fdiv_q      <= 1'b0;
            div_pulse_q <= 1'b0;
            modhi_q     <= 1'b0;
            pa_q        <= 1'b0;
            pb_q        <= 1'b0;
        end else begin
            state_q     <= state_d;
            pcnt_q      <= pcnt_d;
            fdiv_q      <= fdiv_d;
            div_pulse_q <= div_pulse_d;
            modhi_q     <= modhi_d;
            pa_q        <= pa_d;
            pb_q        <= pb_d;
        end
    end

    phase_cmp u_pd (
        .core_clk     (core_clk),
        .rstn         (rstn),
        .ref_pulse    (ref_pulse_q),
        .div_pulse    (div_pulse_q),
        .polarity_sel (pol_s),
        .pd_q         (phase_error_out),
        .pd_oe_n_q    (phase_error_oe_n),
        .lock_n_q     (lock_n)
    );

    // ******************************************************
    // apb registers, no wait state on any transfer
    // ******************************************************
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_q && pwrite;

    always_comb begin
        run_d     = run_q;
        clr_d     = 1'b0;
        valid_d   = valid_q | load;
        prdata_d  = 32'h00000000;
        pready_d  = setup;
        pslverr_d = 1'b0;
        if (wr_en && paddr == pll_synth_pkg::REG_CTRL) begin
            run_d = pwdata[pll_synth_pkg::CTRL_RUN_BIT];
            clr_d = pwdata[pll_synth_pkg::CTRL_CLR_BIT];
        end
        if (setup) begin
            case (paddr)
                pll_synth_pkg::REG_CTRL: begin
                    prdata_d[pll_synth_pkg::CTRL_RUN_BIT] = run_q;
                end
                pll_synth_pkg::REG_STATUS: begin
                    prdata_d[pll_synth_pkg::STAT_LOCK_BIT] = lock_n;
                    prdata_d[pll_synth_pkg::STAT_VLD_BIT]  = valid_d;
                    prdata_d[pll_synth_pkg::STAT_CNT_LSB +: 5] = count;
                end
                pll_synth_pkg::REG_WORD: begin
                    prdata_d[20:0] = word;
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            run_q     <= pll_synth_pkg::CTRL_RUN_RST;
            clr_q     <= 1'b0;
            valid_q   <= 1'b0;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            run_q     <= run_d;
            clr_q     <= clr_d;
            valid_q   <= valid_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign modulus_hi     = modhi_q;
    assign port_out_a     = pa_q;
    assign port_out_b     = pb_q;
    assign ref_div8_clock = div8_q;

    // ******************************************************
    // checks
    // ******************************************************
    AST_PORT: assert property (@(posedge core_clk) disable iff (!rstn)
        !test_s |=> port_out_a == $past(word[19]) &&
                    port_out_b == $past(word[20]))
        else $error("port outputs not following word");
    AST_TEST: assert property (@(posedge core_clk) disable iff (!rstn)
        test_s |=> port_out_a == $past(fcmp_q) &&
                   port_out_b == $past(fdiv_q))
        else $error("test mode outputs wrong");
    AST_MODHI: assert property (@(posedge core_clk) disable iff (!rstn)
        modulus_hi |-> pcnt_q < {3'h0, swallow} || $changed(word))
        else $error("high modulus outside swallow phase");
    AST_DIV8: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(ref_div8_clock) |-> $past(ref_rise) &&
                                     $past(d8cnt_q) == 2'h3)
        else $error("divide by eight clock toggled early");
    AST_APB: assert property (@(posedge core_clk) disable iff (!rstn)
        setup |=> pready ##1 !pready)
        else $error("apb answer not single cycle");
    COV_TEST: cover property (@(posedge core_clk) disable iff (!rstn)
        test_s && div_pulse_q);
    COV_SWALLOW: cover property (@(posedge core_clk) disable iff (!rstn)
        $fell(modulus_hi));

endmodule // serial_pll_synth_core

// *** tb/serial_host.sv ***
// host controller model driving the three-wire serial load lines
`timescale 1ns/1ns
module serial_host (
    input  wire logic core_clk,
    output logic      shift_clock,
    output logic      serial_data,
    output logic      load_clear
);
    initial begin
        shift_clock = 1'b0;
        serial_data = 1'b0;
        load_clear  = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // pulse load clear, then drop it before any shifting
    task automatic clear();
        load_clear <= 1'b1;
        hold(8);
        load_clear <= 1'b0;
        hold(8);
    endtask
    // bit 1 goes first; lc high keeps load clear up to provoke refusal
    task automatic send(input logic [20:0] w, input int n, input logic lc);
        load_clear <= lc;
        for (int i = 0; i < n; i++) begin
            serial_data <= w[i % 21];
            shift_clock <= 1'b1;
            hold(8);
            shift_clock <= 1'b0;
            hold(8);
        end
        // released line shows no stale value
        serial_data <= ~serial_data;
        load_clear  <= 1'b0;
        hold(8);
    endtask
endmodule // serial_host

// *** tb/tb.sv ***
// self-checking bench for the synthesizer core
`timescale 1ns/1ns
module tb;
    // ********************
    // stimulus and wiring
    // ********************
    logic        core_clk, rstn, ref_osc_in, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, e, port_out_a, port_out_b;
    logic        shift_clock, serial_data, load_clear;
    logic        prescaler_in, polarity_sel, test_mode, lock_n;
    int          fail_count, samples_checked, cyc;
    logic [20:0] w1, w2;
    serial_host host_u (.core_clk(core_clk), .shift_clock(shift_clock),
        .serial_data(serial_data), .load_clear(load_clear));
    serial_pll_synth_core dut_u (.core_clk(core_clk), .rstn(rstn),
        .shift_clock(shift_clock), .serial_data(serial_data),
        .load_clear(load_clear), .polarity_sel(polarity_sel),
        .test_mode(test_mode), .ref_osc_in(ref_osc_in),
        .prescaler_in(prescaler_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .modulus_hi(), .port_out_a(port_out_a), .port_out_b(port_out_b),
        .phase_error_out(), .phase_error_oe_n(), .lock_n(lock_n),
        .ref_div8_clock());
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // reference oscillator kept unrelated in phase to the core clock
    initial begin
        ref_osc_in = 1'b0;
        forever #39 ref_osc_in <= ~ref_osc_in;
    end
    // prescaler output, each level long enough to meet a clock edge
    initial begin
        prescaler_in = 1'b0;
        forever #13 prescaler_in <= ~prescaler_in;
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("fails=%0d checks=%0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    // ********************
    // test sequence
    // ********************
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, test_mode} = '0;
        polarity_sel = 1'b1;
        {fail_count, samples_checked, cyc} = '0;
        w1 = {1'b0, 1'b1, 2'b11, 10'h258, 7'h5C};
        w2 = {1'b1, 1'b0, 2'b00, 10'h3FF, 7'h7F};
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h00000001);
        apb(1'b0, 12'h004, 32'h0);
        chk(r & 32'h7E, 32'h00000000);
        // zero word divides every prescaler edge: long errors, unlocked
        repeat (2500) @(posedge core_clk);
        chk(lock_n, 32'h00000001);
        host_u.clear();
        host_u.send(w1, 21, 1'b0);
        repeat (20) @(posedge core_clk);
        apb(1'b0, 12'h008, 32'h0);
        chk(r, {11'h000, w1});
        chk({port_out_b, port_out_a}, {w1[20], w1[19]});
        host_u.send(w2, 5, 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk(r, {11'h000, w1});
        apb(1'b0, 12'h004, 32'h0);
        chk(r & 32'h7E, 32'h00000056);
        host_u.clear();
        host_u.send(w2, 5, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(r & 32'h7E, 32'h00000002);
        host_u.send(w2, 21, 1'b0);
        repeat (20) @(posedge core_clk);
        apb(1'b0, 12'h008, 32'h0);
        chk(r, {11'h000, w2});
        chk({port_out_b, port_out_a}, {w2[20], w2[19]});
        apb(1'b1, 12'h000, 32'h00000003);
        apb(1'b0, 12'h004, 32'h0);
        chk(r & 32'h7E, 32'h00000002);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({r[30:0], e}, 32'h00000001);
        polarity_sel <= 1'b0;
        repeat (2000) @(posedge core_clk);
        test_mode <= 1'b1;
        repeat (2000) @(posedge core_clk);
        close_out();
    end
endmodule // tb
